//--- hw/ihpm_consts.svh
`ifndef IHPM_CONSTS_SVH
`define IHPM_CONSTS_SVH

// ==========================================================================
// Pin numbering inside the block
`define IHPM_NPINS 2
`define IHPM_PIN_INDEX 0
`define IHPM_PIN_HOME 1

// ==========================================================================
// Port C pull-up enable register layout
`define IHPM_PUR_W 4
`define IHPM_PUR_BIT_INDEX 2
`define IHPM_PUR_BIT_HOME 3

// ==========================================================================
// Reset and idle levels
`define IHPM_PULLUP_RST 1'b1
`define IHPM_OE_N_OFF 1'b1
`define IHPM_OE_N_ON 1'b0
`define IHPM_PAD_OUT_RST 1'b0
`define IHPM_LEVEL_IDLE 1'b1
`define IHPM_SS_ACTIVE 1'b0
`define IHPM_SS_IDLE 1'b1

`endif

//--- hw/ihpm_pad_sel.sv
`timescale 1ns/10ps
// ==========================================================================
// Per-pin output steering: only the selected function reaches the pad
module ihpm_pad_sel (
  // Selection
  input wire ihpm_pkg::ihpm_func_t func_in,
  // Function requests
  input wire ihpm_pkg::ihpm_drive_t timer_drv_in,
  input wire ihpm_pkg::ihpm_drive_t spi_drv_in,
  input wire ihpm_pkg::ihpm_drive_t gpio_drv_in,
  // Steered request
  output ihpm_pkg::ihpm_drive_t drv_out
);

  always_comb begin
    drv_out = '0;
    unique case (func_in)
      ihpm_pkg::IHPM_FUNC_NONE: begin
        drv_out = '0;
      end
      ihpm_pkg::IHPM_FUNC_DECODER: begin
        drv_out = '0;
      end
      ihpm_pkg::IHPM_FUNC_TIMER: begin
        drv_out = timer_drv_in; // RL16
      end
      ihpm_pkg::IHPM_FUNC_SPI: begin
        drv_out = spi_drv_in; // RL16
      end
      ihpm_pkg::IHPM_FUNC_GPIO: begin
        drv_out = gpio_drv_in; // RL16
      end
      default: begin
        drv_out = '0;
      end
    endcase
  end

endmodule : ihpm_pad_sel

//--- hw/ihpm_pkg.sv
// ==========================================================================
// Types shared by the pin multiplexer files
package ihpm_pkg;

  // Selected function of one pin
  typedef enum logic [2:0] {
    IHPM_FUNC_NONE    = 3'b000,
    IHPM_FUNC_DECODER = 3'b001,
    IHPM_FUNC_TIMER   = 3'b010,
    IHPM_FUNC_SPI     = 3'b011,
    IHPM_FUNC_GPIO    = 3'b100
  } ihpm_func_t;

  // Output request of one function towards one pad
  typedef struct packed {
    logic oe;
    logic val;
  } ihpm_drive_t;

  // Function configuration, loaded on a configuration strobe
  typedef struct packed {
    logic [1:0] gpio_mode;
    logic [1:0] timer_mode;
    logic index_pin_alternate_select;
    logic home_pin_alternate_select;
  } ihpm_cfg_t;

endpackage : ihpm_pkg

//--- hw/ihpm_top.sv
`timescale 1ns/10ps
// Summary of operation
// RL1: Full variant: index pin comes out of reset as decoder index input.
// RL2: Full variant: home pin comes out of reset as decoder home input.
// RL3: Reduced variant: pins select no function until software configures.
// RL4: Index pin level feeds the decoder index input when decoder selected.
// RL5: Home pin level feeds the decoder home input when decoder selected.
// RL6: Index alternate select bit routes serial MISO onto the index pin.
// RL7: Home alternate select bit routes serial slave select to the home pin.
// RL8: Clearing pull-up bit 2 removes the index pin pull-up.
// RL9: Clearing pull-up bit 3 removes the home pin pull-up.
// RL10: In GPIO mode each pin is an input or output on its own.
// RL11: MISO is sampled by a master and driven by a slave.
// RL12: Unselected slave leaves MISO undriven.
// RL13: Slave data sits on MISO half a serial clock before latching.
// RL14: In master mode slave select is an input flagging master contention.
// RL15: In slave mode asserted slave select addresses this device.
// RL16: Only the selected function drives the pad; all see its level. The serial interface sees it only on a pin set to the serial function.
`include "ihpm_consts.svh"

module ihpm_top (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Variant strap, caught while reset is held
  input wire logic full_variant_in,
  // Function configuration
  input wire logic cfg_load_in,
  input wire ihpm_pkg::ihpm_cfg_t cfg_in,
  input wire logic [`IHPM_PUR_W-1:0] port_c_pullup_enable_register_in,
  // General purpose port
  input wire logic [`IHPM_NPINS-1:0] gpio_dir_in,
  input wire logic [`IHPM_NPINS-1:0] gpio_data_in,
  output logic [`IHPM_NPINS-1:0] port_c_pin_level_out,
  // Timer B channels two and three
  input wire ihpm_pkg::ihpm_drive_t [`IHPM_NPINS-1:0] timer_drive_in,
  output logic [`IHPM_NPINS-1:0] timer_level_out,
  // Quadrature decoder 1
  output logic decoder_index_input_out,
  output logic decoder_home_input_out,
  // Serial interface 1
  input wire logic spi_master_mode_in,
  input wire logic spi_miso_data_in,
  output logic serial1_master_in_slave_out_out,
  output logic serial1_slave_select_out,
  output logic spi_mode_fault_out,
  output logic spi_slave_selected_out,
  // Pads
  input wire logic [`IHPM_NPINS-1:0] pad_in_in,
  output logic [`IHPM_NPINS-1:0] pad_out_out,
  output logic [`IHPM_NPINS-1:0] pad_oe_n_out,
  output logic [`IHPM_NPINS-1:0] pad_pullup_out,
  // Status
  output ihpm_pkg::ihpm_func_t [`IHPM_NPINS-1:0] pin_func_out
);

  // ========================================================================
  // Function selection
  ihpm_pkg::ihpm_func_t [`IHPM_NPINS-1:0] func_ff;
  ihpm_pkg::ihpm_func_t [`IHPM_NPINS-1:0] nxt_func;
  logic [`IHPM_NPINS-1:0] alt_sel;

  assign alt_sel[`IHPM_PIN_INDEX] = cfg_in.index_pin_alternate_select;
  assign alt_sel[`IHPM_PIN_HOME] = cfg_in.home_pin_alternate_select;

  // GPIO wins, then the alternate serial function, then the timer
  always_comb begin
    for (int i = 0; i < `IHPM_NPINS; i++) begin
      if (cfg_in.gpio_mode[i]) begin
        nxt_func[i] = ihpm_pkg::IHPM_FUNC_GPIO; // RL10
      end else if (alt_sel[i]) begin
        nxt_func[i] = ihpm_pkg::IHPM_FUNC_SPI; // RL6 RL7
      end else if (cfg_in.timer_mode[i]) begin
        nxt_func[i] = ihpm_pkg::IHPM_FUNC_TIMER;
      end else begin
        nxt_func[i] = ihpm_pkg::IHPM_FUNC_DECODER;
      end
    end
  end

  // Reset default depends on the variant strap
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < `IHPM_NPINS; i++) begin
        if (full_variant_in) begin
          func_ff[i] <= ihpm_pkg::IHPM_FUNC_DECODER; // RL1 RL2
        end else begin
          func_ff[i] <= ihpm_pkg::IHPM_FUNC_NONE; // RL3
        end
      end
    end else if (cfg_load_in) begin
      func_ff <= nxt_func;
    end
  end

  assign pin_func_out = func_ff;

  // ========================================================================
  // Serial interface pin roles
  logic spi_on_index;
  logic spi_on_home;
  logic ss_level;
  logic nxt_selected;
  logic nxt_fault;

  assign spi_on_index = func_ff[`IHPM_PIN_INDEX] == ihpm_pkg::IHPM_FUNC_SPI;
  assign spi_on_home = func_ff[`IHPM_PIN_HOME] == ihpm_pkg::IHPM_FUNC_SPI;
  assign ss_level = spi_on_home ? pad_in_in[`IHPM_PIN_HOME] : `IHPM_SS_IDLE;
  assign nxt_selected = !spi_master_mode_in &&
                        (ss_level == `IHPM_SS_ACTIVE); // RL15
  assign nxt_fault = spi_master_mode_in &&
                     (ss_level == `IHPM_SS_ACTIVE); // RL14

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      serial1_slave_select_out <= `IHPM_SS_IDLE;
      spi_slave_selected_out <= 1'b0;
      spi_mode_fault_out <= 1'b0;
    end else begin
      serial1_slave_select_out <= ss_level; // RL7
      spi_slave_selected_out <= nxt_selected; // RL15
      spi_mode_fault_out <= nxt_fault; // RL14
    end
  end

  // Master samples MISO; idle high when the pin is elsewhere
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      serial1_master_in_slave_out_out <= `IHPM_LEVEL_IDLE;
    end else if (spi_on_index && spi_master_mode_in) begin
      serial1_master_in_slave_out_out <= pad_in_in[`IHPM_PIN_INDEX]; // RL11
    end else begin
      serial1_master_in_slave_out_out <= `IHPM_LEVEL_IDLE;
    end
  end

  // ========================================================================
  // Output steering per pin
  ihpm_pkg::ihpm_drive_t [`IHPM_NPINS-1:0] spi_drv;
  ihpm_pkg::ihpm_drive_t [`IHPM_NPINS-1:0] gpio_drv;
  ihpm_pkg::ihpm_drive_t [`IHPM_NPINS-1:0] pad_drv;

  // Slave drives MISO only while addressed; slave select is never driven
  assign spi_drv[`IHPM_PIN_INDEX].oe = nxt_selected; // RL11 RL12
  assign spi_drv[`IHPM_PIN_INDEX].val = spi_miso_data_in; // RL13
  assign spi_drv[`IHPM_PIN_HOME] = '0; // RL14 RL15

  genvar g;
  generate
    for (g = 0; g < `IHPM_NPINS; g++) begin : g_pin
      assign gpio_drv[g].oe = gpio_dir_in[g]; // RL10
      assign gpio_drv[g].val = gpio_data_in[g];

      ihpm_pad_sel u_pad_sel (
        .func_in(func_ff[g]),
        .timer_drv_in(timer_drive_in[g]),
        .spi_drv_in(spi_drv[g]),
        .gpio_drv_in(gpio_drv[g]),
        .drv_out(pad_drv[g])
      );
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pad_oe_n_out <= {`IHPM_NPINS{`IHPM_OE_N_OFF}};
      pad_out_out <= {`IHPM_NPINS{`IHPM_PAD_OUT_RST}};
    end else begin
      for (int i = 0; i < `IHPM_NPINS; i++) begin
        pad_oe_n_out[i] <= pad_drv[i].oe ? `IHPM_OE_N_ON
                                         : `IHPM_OE_N_OFF; // RL16
        pad_out_out[i] <= pad_drv[i].val;
      end
    end
  end

  // ========================================================================
  // Pull-up control
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pad_pullup_out <= {`IHPM_NPINS{`IHPM_PULLUP_RST}};
    end else begin
      pad_pullup_out[`IHPM_PIN_INDEX] <=
        port_c_pullup_enable_register_in[`IHPM_PUR_BIT_INDEX]; // RL8
      pad_pullup_out[`IHPM_PIN_HOME] <=
        port_c_pullup_enable_register_in[`IHPM_PUR_BIT_HOME]; // RL9
    end
  end

  // ========================================================================
  // Input distribution: decoder, port and timer always see the pad level
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      decoder_index_input_out <= `IHPM_LEVEL_IDLE;
      decoder_home_input_out <= `IHPM_LEVEL_IDLE;
      port_c_pin_level_out <= {`IHPM_NPINS{`IHPM_LEVEL_IDLE}};
      timer_level_out <= {`IHPM_NPINS{`IHPM_LEVEL_IDLE}};
    end else begin
      decoder_index_input_out <= pad_in_in[`IHPM_PIN_INDEX]; // RL4 RL16
      decoder_home_input_out <= pad_in_in[`IHPM_PIN_HOME]; // RL5 RL16
      port_c_pin_level_out <= pad_in_in; // RL10
      timer_level_out <= pad_in_in;
    end
  end

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic rst_q_ff;
  logic strap_q_ff;
  always_ff @(posedge core_clk_in) begin
    rst_q_ff <= rst_n_in;
    strap_q_ff <= full_variant_in;
  end

  sequence s_reset_release;
    !rst_q_ff && rst_n_in;
  endsequence

  property p_full_index_reset;
    (s_reset_release and strap_q_ff) |->
      func_ff[`IHPM_PIN_INDEX] == ihpm_pkg::IHPM_FUNC_DECODER;
  endproperty
  a_full_index_reset: assert property (p_full_index_reset) // RL1
    else $error("index pin not on decoder after reset");

  property p_full_home_reset;
    (s_reset_release and strap_q_ff) |->
      func_ff[`IHPM_PIN_HOME] == ihpm_pkg::IHPM_FUNC_DECODER;
  endproperty
  a_full_home_reset: assert property (p_full_home_reset) // RL2
    else $error("home pin not on decoder after reset");

  property p_reduced_reset;
    (s_reset_release and !strap_q_ff) |->
      func_ff == {`IHPM_NPINS{ihpm_pkg::IHPM_FUNC_NONE}} &&
      pad_oe_n_out == {`IHPM_NPINS{`IHPM_OE_N_OFF}};
  endproperty
  a_reduced_reset: assert property (p_reduced_reset) // RL3
    else $error("reduced variant selected a function at reset");

  property p_index_feed;
    func_ff[`IHPM_PIN_INDEX] == ihpm_pkg::IHPM_FUNC_DECODER |=>
      decoder_index_input_out == $past(pad_in_in[`IHPM_PIN_INDEX]);
  endproperty
  a_index_feed: assert property (p_index_feed) // RL4
    else $error("decoder index does not follow pad");

  property p_home_feed;
    func_ff[`IHPM_PIN_HOME] == ihpm_pkg::IHPM_FUNC_DECODER |=>
      decoder_home_input_out == $past(pad_in_in[`IHPM_PIN_HOME]);
  endproperty
  a_home_feed: assert property (p_home_feed) // RL5
    else $error("decoder home does not follow pad");

  sequence s_load_alt;
    cfg_load_in && !cfg_in.gpio_mode[`IHPM_PIN_INDEX] &&
      cfg_in.index_pin_alternate_select;
  endsequence

  property p_alt_index;
    s_load_alt |=> func_ff[`IHPM_PIN_INDEX] == ihpm_pkg::IHPM_FUNC_SPI;
  endproperty
  a_alt_index: assert property (p_alt_index) // RL6
    else $error("index alternate select did not route serial data");

  property p_pullup;
    ##1 pad_pullup_out[`IHPM_PIN_INDEX] ==
      $past(port_c_pullup_enable_register_in[`IHPM_PUR_BIT_INDEX]) &&
    pad_pullup_out[`IHPM_PIN_HOME] ==
      $past(port_c_pullup_enable_register_in[`IHPM_PUR_BIT_HOME]);
  endproperty
  a_pullup: assert property (p_pullup) // RL8 RL9
    else $error("pull-up does not follow its enable bit");

  property p_gpio_dir;
    func_ff[`IHPM_PIN_HOME] == ihpm_pkg::IHPM_FUNC_GPIO |=>
      pad_oe_n_out[`IHPM_PIN_HOME] == !$past(gpio_dir_in[`IHPM_PIN_HOME]);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) // RL10
    else $error("gpio direction not applied to home pin");

  property p_miso_idle;
    spi_on_index && !(nxt_selected) |=>
      pad_oe_n_out[`IHPM_PIN_INDEX] == `IHPM_OE_N_OFF;
  endproperty
  a_miso_idle: assert property (p_miso_idle) // RL12
    else $error("miso driven while slave not selected");

  property p_fault;
    spi_on_home && spi_master_mode_in &&
      pad_in_in[`IHPM_PIN_HOME] == `IHPM_SS_ACTIVE |=>
      spi_mode_fault_out && !spi_slave_selected_out;
  endproperty
  a_fault: assert property (p_fault) // RL14
    else $error("master contention not flagged");

  property p_slave_select;
    spi_on_home && spi_on_index && !spi_master_mode_in &&
      pad_in_in[`IHPM_PIN_HOME] == `IHPM_SS_ACTIVE |=>
      spi_slave_selected_out &&
      pad_oe_n_out[`IHPM_PIN_INDEX] == `IHPM_OE_N_ON &&
      pad_out_out[`IHPM_PIN_INDEX] == $past(spi_miso_data_in);
  endproperty
  a_slave_select: assert property (p_slave_select) // RL11 RL13 RL15
    else $error("addressed slave does not drive miso");

  property p_no_drive_unselected;
    func_ff[`IHPM_PIN_INDEX] == ihpm_pkg::IHPM_FUNC_DECODER ##1
      func_ff[`IHPM_PIN_INDEX] == ihpm_pkg::IHPM_FUNC_DECODER |->
      pad_oe_n_out[`IHPM_PIN_INDEX] == `IHPM_OE_N_OFF;
  endproperty
  a_no_drive_unselected: assert property (p_no_drive_unselected) // RL16
    else $error("pad driven by a deselected function");

endmodule : ihpm_top

//--- tb/ihpm_far_model.sv
`timescale 1ns/10ps
// ==========================================================================
// Far side of both pads: encoder, serial peer or open line
module ihpm_far_model (
  // Clock
  input wire logic core_clk_in,
  // Device pad drive
  input wire logic [1:0] pad_out_in,
  input wire logic [1:0] pad_oe_n_in,
  input wire logic [1:0] pad_pullup_in,
  // External drivers
  input wire logic [1:0] ext_en_in,
  input wire logic [1:0] ext_val_in,
  // Resolved pad levels
  output logic [1:0] pad_level_out
);
  logic [1:0] float_ff = 2'h1;

  // An open line with no pull-up wanders every cycle
  always_ff @(posedge core_clk_in) begin
    float_ff <= ~float_ff;
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (!pad_oe_n_in[i]) begin
        // Slave data seen by the master only while the device drives
        pad_level_out[i] = pad_out_in[i];
      end else if (ext_en_in[i]) begin
        // Peer drives select low or presents data to a master device
        pad_level_out[i] = ext_val_in[i];
      end else if (pad_pullup_in[i]) begin
        pad_level_out[i] = 1'b1;
      end else begin
        pad_level_out[i] = float_ff[i];
      end
    end
  end
endmodule : ihpm_far_model

//--- tb/test_ihpm_top.sv
`timescale 1ns/10ps
module test_ihpm_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b1;
  logic cfg_load = 1'b0;
  logic [5:0] cfg = 6'h00;
  logic [3:0] pur = 4'hf;
  logic [1:0] gdir = 2'h0;
  logic [1:0] gdat = 2'h0;
  logic [3:0] tdrv = 4'h0;
  logic master = 1'b0;
  logic miso_d = 1'b0;
  logic [1:0] ext_en = 2'h0;
  logic [1:0] ext_val = 2'h0;
  logic [1:0] pad_lvl;
  logic [1:0] pin_lvl;
  logic [1:0] tmr_lvl;
  logic idx;
  logic home;
  logic miso_o;
  logic ss_o;
  logic fault;
  logic sel;
  logic [1:0] pad_o;
  logic [1:0] oe_n;
  logic [1:0] pu;
  ihpm_pkg::ihpm_func_t [1:0] func;
  int num_errors = 0;
  int comparisons = 0;

  always #25 clk = ~clk;

  ihpm_top dut_u (
    .core_clk_in(clk), .rst_n_in(rst_n), .full_variant_in(strap),
    .cfg_load_in(cfg_load), .cfg_in(ihpm_pkg::ihpm_cfg_t'(cfg)),
    .port_c_pullup_enable_register_in(pur),
    .gpio_dir_in(gdir), .gpio_data_in(gdat), .port_c_pin_level_out(pin_lvl),
    .timer_drive_in(tdrv), .timer_level_out(tmr_lvl),
    .decoder_index_input_out(idx), .decoder_home_input_out(home),
    .spi_master_mode_in(master), .spi_miso_data_in(miso_d),
    .serial1_master_in_slave_out_out(miso_o),
    .serial1_slave_select_out(ss_o), .spi_mode_fault_out(fault),
    .spi_slave_selected_out(sel), .pad_in_in(pad_lvl),
    .pad_out_out(pad_o), .pad_oe_n_out(oe_n), .pad_pullup_out(pu),
    .pin_func_out(func)
  );

  ihpm_far_model far_u (
    .core_clk_in(clk), .pad_out_in(pad_o), .pad_oe_n_in(oe_n),
    .pad_pullup_in(pu), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pad_level_out(pad_lvl)
  );

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic [5:0] act, input logic [5:0] exp);
    comparisons++;
    if (act !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, act, exp);
    end
  endtask : chk

  task automatic do_reset(input logic full);
    rst_n = 1'b0;
    strap = full;
    repeat (6) step();
    rst_n = 1'b1;
  endtask : do_reset

  // Load strobe, then two cycles until the pads follow
  task automatic load_cfg(input logic [5:0] c);
    cfg = c;
    cfg_load = 1'b1;
    step();
    cfg_load = 1'b0;
    step();
    step();
  endtask : load_cfg

  task automatic finish_test;
    if (num_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  initial begin
    #1;
    do_reset(1'b1);
    chk(func, {2{ihpm_pkg::IHPM_FUNC_DECODER}});
    chk({2'h0, oe_n, pu}, 6'h0f);
    // Decoder inputs follow the pads
    ext_en = 2'h3;
    ext_val = 2'h2;
    step();
    step();
    chk({4'h0, home, idx}, 6'h02);
    ext_val = 2'h1;
    step();
    step();
    chk({4'h0, home, idx}, 6'h01);
    // Pull-up enables
    pur = 4'h4;
    step();
    chk({4'h0, pu}, 6'h01);
    pur = 4'h8;
    step();
    chk({4'h0, pu}, 6'h02);
    pur = 4'hf;
    // General purpose, each pin its own direction
    ext_en = 2'h0;
    gdir = 2'h1;
    gdat = 2'h3;
    load_cfg(6'h30);
    chk(func, {ihpm_pkg::IHPM_FUNC_GPIO, ihpm_pkg::IHPM_FUNC_GPIO});
    chk({3'h0, oe_n, pad_o[0]}, 6'h05);
    gdir = 2'h2;
    gdat = 2'h0;
    step();
    chk({3'h0, oe_n, pad_o[1]}, 6'h02);
    step();
    chk({4'h0, pin_lvl}, 6'h01);
    // Timer owns the pads, direction bits ignored
    tdrv = 4'h3;
    load_cfg(6'h0c);
    chk(func, {ihpm_pkg::IHPM_FUNC_TIMER, ihpm_pkg::IHPM_FUNC_TIMER});
    chk({3'h0, oe_n, pad_o[0]}, 6'h05);
    // Serial slave, alternate select above timer
    master = 1'b0;
    miso_d = 1'b1;
    ext_en = 2'h2;
    ext_val = 2'h0;
    load_cfg(6'h0f);
    step();
    chk(func, {ihpm_pkg::IHPM_FUNC_SPI, ihpm_pkg::IHPM_FUNC_SPI});
    chk({sel, ss_o, fault, oe_n, pad_o[0]}, 6'h25);
    miso_d = 1'b0;
    step();
    chk({sel, ss_o, fault, oe_n, pad_o[0]}, 6'h24);
    ext_val = 2'h2;
    step();
    step();
    chk({sel, ss_o, fault, oe_n, 1'b0}, 6'h16);
    // Serial master: slave select flags contention, MISO sampled
    master = 1'b1;
    ext_en = 2'h3;
    ext_val = 2'h0;
    step();
    step();
    chk({1'b0, fault, sel, miso_o, oe_n}, 6'h13);
    ext_val = 2'h1;
    step();
    step();
    chk({1'b0, fault, sel, miso_o, oe_n}, 6'h17);
    chk({2'h0, tmr_lvl, pin_lvl}, 6'h05);
    ext_val = 2'h3;
    step();
    step();
    chk({1'b0, fault, sel, miso_o, oe_n}, 6'h07);
    // Reduced variant comes up with no function
    ext_en = 2'h0;
    do_reset(1'b0);
    chk(func, {ihpm_pkg::IHPM_FUNC_NONE, ihpm_pkg::IHPM_FUNC_NONE});
    chk({4'h0, oe_n}, 6'h03);
    finish_test();
  end
endmodule : test_ihpm_top
